// [hw/quad_nibble_io_ports.sv]
`timescale 1ns/1ps
// Functional notes
// - Edge select bit: 0 falling edges flag, 1 rising edges flag, both ports.
// - First-port bypass bit 0 debounces first-port interrupt inputs, 1 bypasses them; branch tests stay debounced.
// - Third-port bypass bit 0 debounces, 1 feeds third-port pins straight to interrupts.
// - Option bit 0 resets to 0; 1 disables watchdog, exported outward.
// - Debounced level changes after holding across two consecutive debounce clock rises.
// - First-port status read returns sampled pins regardless of debouncing; read-only.
// - Debounced first-port pins 0, 1, 2 drive branch test inputs 1, 2, 3.
// - Per-pin first-port mask bits gate interrupt edges; masks reset to 0.
// - First-port flag register clears on reset and on every read; not writable.
// - Reading first-port flags also clears the first-port summary flag.
// - Second-port direction 0 input high impedance, 1 drives written data bit.
// - Second-port direction bits clear at reset, all pins start as inputs.
// - Blocked-on-output option hides true output pin levels from reads.
// - High-impedance-in-sleep option tristates active outputs while sleeping.
// - One third-port direction bit: 1 all outputs, 0 all inputs.
// - Third port has own mask and read-clearing flags, only while input.
// - Third-port direction and mask clear at reset: input, interrupts off.
// - Combine bit 0 ORs port requests, 1 requires both pending.
module quad_nibble_io_ports #(
    parameter int FAST_DIV                = quad_nibble_pkg::FAST_TAP_CYCLES,
    parameter int SLOW_DIV                = quad_nibble_pkg::SLOW_TAP_CYCLES,
    parameter bit INPUT_BLOCKED_ON_OUTPUT = 1'b0,
    parameter bit HIZ_IN_SLEEP            = 1'b0
) (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Register port.
    input  wire logic [3:0] addr,
    input  wire logic [3:0] wrData,
    input  wire logic       wrStrobe,
    input  wire logic       rdStrobe,
    output logic      [3:0] rdData,
    // First port pins.
    input  wire logic [3:0] portAIn,
    // Second port pins.
    input  wire logic [3:0] portBIn,
    output logic      [3:0] portBOut,
    output logic      [3:0] portBOe_n,
    // Third port pins.
    input  wire logic [3:0] portCIn,
    output logic      [3:0] portCOut,
    output logic      [3:0] portCOe_n,
    // System side.
    input  wire logic       sleepMode,
    input  wire logic       debounceSlowSelect,
    output logic            watchdogDisable,
    output logic            branchTest1,
    output logic            branchTest2,
    output logic            branchTest3,
    output logic            cpuIrqRequest
);
    import quad_nibble_pkg::*;

    // Refuse dividers that cannot produce a tick or do not fit the counter.
    // A divider of one would tick every cycle and defeat the two-tick filter.
    if (FAST_DIV < 2 || SLOW_DIV < 2 || FAST_DIV >= (1 << DIV_WIDTH) ||
        SLOW_DIV >= (1 << DIV_WIDTH)) begin : g_bad_divider
        $error("quad_nibble_io_ports: divider out of range");
    end

    logic [3:0] portOptions;
    logic [3:0] firstIrqMask;
    logic [3:0] firstIrqFlags;
    logic [3:0] secondPortData;
    logic [3:0] secondPortDirection;
    logic [3:0] thirdPortData;
    logic [3:0] thirdIrqMask;
    logic [3:0] thirdIrqFlags;
    logic [1:0] portControl;
    logic [3:0] aSync1, aSync2, bSync1, bSync2, cSync1, cSync2;
    logic [3:0] aSample, aStable, cSample, cStable;
    logic [3:0] aPrev, cPrev;
    logic [DIV_WIDTH-1:0] divCount;

    // Pin synchronisers; the first stage feeds only the second.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aSync1 <= NIBBLE_RESET;
            aSync2 <= NIBBLE_RESET;
            bSync1 <= NIBBLE_RESET;
            bSync2 <= NIBBLE_RESET;
            cSync1 <= NIBBLE_RESET;
            cSync2 <= NIBBLE_RESET;
        end else begin
            aSync1 <= portAIn;
            aSync2 <= aSync1;
            bSync1 <= portBIn;
            bSync2 <= bSync1;
            cSync1 <= portCIn;
            cSync2 <= cSync1;
        end
    end

    // Debounce tick divider; one counter serves both taps to save area.
    wire [DIV_WIDTH-1:0] divLimit = debounceSlowSelect ?
                                    DIV_WIDTH'(SLOW_DIV - 1) : DIV_WIDTH'(FAST_DIV - 1);
    wire                 debTick  = (divCount >= divLimit);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            divCount <= '0;
        end else if (debTick) begin
            divCount <= '0;
        end else begin
            divCount <= divCount + 1'b1;
        end
    end

    // Debouncers: a level is taken once two consecutive ticks saw it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aSample <= NIBBLE_RESET;
            aStable <= NIBBLE_RESET;
            cSample <= NIBBLE_RESET;
            cStable <= NIBBLE_RESET;
        end else if (debTick) begin
            aSample <= aSync2;
            cSample <= cSync2;
            aStable <= (aSample & aSync2) | (aStable & (aSample ^ aSync2));
            cStable <= (cSample & cSync2) | (cStable & (cSample ^ cSync2));
        end
    end

    // Interrupt source selection and edge detection.
    wire       risingSel   = portOptions[OPT_RISING_SELECT];
    wire       thirdIsOut  = portControl[CTL_THIRD_DIRECTION];
    wire [3:0] aSource     = portOptions[OPT_FIRST_BYPASS] ? aSync2 : aStable;
    wire [3:0] cSource     = portOptions[OPT_THIRD_BYPASS] ? cSync2 : cStable;
    wire [3:0] aEdge       = risingSel ? (aSource & ~aPrev) : (~aSource & aPrev);
    wire [3:0] cEdge       = risingSel ? (cSource & ~cPrev) : (~cSource & cPrev);
    wire [3:0] aSet        = aEdge & firstIrqMask;
    wire [3:0] cSet        = thirdIsOut ? 4'h0 : (cEdge & thirdIrqMask);

    // Masked edges of each polarity, named so the checks can look back at them.
    // They are not used by the logic itself, only by the checks below.
    wire [3:0] aFallMasked = aPrev & ~aSource & firstIrqMask;
    wire [3:0] aRiseMasked = ~aPrev & aSource & firstIrqMask;
    wire [3:0] cFallMasked = cPrev & ~cSource & thirdIrqMask & {4{~thirdIsOut}};
    wire [3:0] cRiseMasked = ~cPrev & cSource & thirdIrqMask & {4{~thirdIsOut}};

    // Edge history follows the selected source, so a bypass change may raise one edge.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aPrev <= NIBBLE_RESET;
            cPrev <= NIBBLE_RESET;
        end else begin
            aPrev <= aSource;
            cPrev <= cSource;
        end
    end

    // Address decode.
    wire wrOptions = wrStrobe && (addr == ADDR_OPTIONS);
    wire wrAMask   = wrStrobe && (addr == ADDR_A_MASK);
    wire wrBData   = wrStrobe && (addr == ADDR_B_DATA);
    wire wrBDir    = wrStrobe && (addr == ADDR_B_DIR);
    wire wrCData   = wrStrobe && (addr == ADDR_C_DATA);
    wire wrControl = wrStrobe && (addr == ADDR_CONTROL);
    wire wrCMask   = wrStrobe && (addr == ADDR_C_MASK);
    wire rdAFlags  = rdStrobe && (addr == ADDR_A_FLAGS);
    wire rdCFlags  = rdStrobe && (addr == ADDR_C_FLAGS);

    // Software registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            portOptions         <= NIBBLE_RESET;
            firstIrqMask        <= NIBBLE_RESET;
            secondPortData      <= NIBBLE_RESET;
            secondPortDirection <= NIBBLE_RESET;
            thirdPortData       <= NIBBLE_RESET;
            thirdIrqMask        <= NIBBLE_RESET;
            portControl         <= 2'h0;
        end else begin
            if (wrOptions) portOptions <= wrData;
            if (wrAMask) firstIrqMask <= wrData;
            if (wrBData) secondPortData <= wrData;
            if (wrBDir) secondPortDirection <= wrData;
            if (wrCData) thirdPortData <= wrData;
            if (wrCMask) thirdIrqMask <= wrData;
            if (wrControl) portControl <= wrData[1:0];
        end
    end

    // Flags clear on read, but an edge in the clearing cycle still sets its bit.
    wire [3:0] next_firstIrqFlags = (rdAFlags ? 4'h0 : firstIrqFlags) | aSet;
    wire [3:0] next_thirdIrqFlags = (rdCFlags ? 4'h0 : thirdIrqFlags) | cSet;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            firstIrqFlags <= NIBBLE_RESET;
            thirdIrqFlags <= NIBBLE_RESET;
        end else begin
            firstIrqFlags <= next_firstIrqFlags;
            thirdIrqFlags <= next_thirdIrqFlags;
        end
    end

    // Port requests; the summary flag falls with the flags it summarises.
    wire firstSummary = |firstIrqFlags;
    wire thirdSummary = |thirdIrqFlags;
    wire andCombine   = portControl[CTL_AND_COMBINE];
    assign cpuIrqRequest = andCombine ? (firstSummary && thirdSummary)
                                      : (firstSummary || thirdSummary);

    // Pin drive; sleep tristating only exists when the build option is present.
    wire       sleepHiz = HIZ_IN_SLEEP && sleepMode;
    wire [3:0] thirdDir = {4{thirdIsOut}};
    assign portBOut  = secondPortData;
    assign portBOe_n = ~(secondPortDirection & {4{~sleepHiz}});
    assign portCOut  = thirdPortData;
    assign portCOe_n = ~(thirdDir & {4{~sleepHiz}});

    // Data reads: with blocking, output bits read as zero, so read-modify-write needs an image.
    wire [3:0] bBlock   = INPUT_BLOCKED_ON_OUTPUT ? secondPortDirection : 4'h0;
    wire [3:0] cBlock   = INPUT_BLOCKED_ON_OUTPUT ? thirdDir : 4'h0;
    wire [3:0] bReadVal = bSync2 & ~bBlock;
    wire [3:0] cReadVal = cSync2 & ~cBlock;

    // Read multiplexer.
    logic [3:0] next_rdData;
    always_comb begin
        case (addr)
            ADDR_OPTIONS:     next_rdData = portOptions;
            ADDR_A_STATUS:    next_rdData = aSync2;
            ADDR_A_FLAGS:     next_rdData = firstIrqFlags;
            ADDR_A_MASK:      next_rdData = firstIrqMask;
            ADDR_B_DATA:      next_rdData = bReadVal;
            ADDR_B_DIR:       next_rdData = secondPortDirection;
            ADDR_C_DATA:      next_rdData = cReadVal;
            ADDR_CONTROL:     next_rdData = {2'h0, portControl};
            ADDR_C_MASK:      next_rdData = thirdIrqMask;
            ADDR_C_FLAGS:     next_rdData = thirdIrqFlags;
            ADDR_IRQ_REQUEST: next_rdData = {2'h0, thirdSummary, firstSummary};
            default:          next_rdData = READ_UNMAPPED;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData <= NIBBLE_RESET;
        end else begin
            rdData <= rdStrobe ? next_rdData : NIBBLE_RESET;
        end
    end

    // Exports to the watchdog and the branch unit.
    assign watchdogDisable = portOptions[OPT_WATCHDOG_DISABLE];
    assign branchTest1     = aStable[0];
    assign branchTest2     = aStable[1];
    assign branchTest3     = aStable[2];

    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    edge_sets_flag_a: assert property (|aSet |=> ((firstIrqFlags & $past(aSet)) == $past(aSet)))
        else $error("masked first-port edge did not set its flag");
    read_clears_a: assert property (rdAFlags && !(|aSet) |=> firstIrqFlags == 4'h0)
        else $error("first-port flags survived a read");
    read_returns_a: assert property (rdAFlags |=> rdData == $past(firstIrqFlags))
        else $error("flag read returned wrong value");
    summary_clears_a: assert property (rdAFlags && !(|aSet) |=> !firstSummary)
        else $error("summary flag survived flag read");
    mask_gates_a: assert property ((aEdge & ~firstIrqMask) != 4'h0 && !rdAFlags |=>
        ((firstIrqFlags & ~$past(firstIrqFlags)) & ~$past(firstIrqMask)) == 4'h0)
        else $error("unmasked pin raised a flag");
    third_out_quiet_a: assert property (thirdIsOut && rdCFlags |=> thirdIrqFlags == 4'h0)
        else $error("third-port flag set while output");
    combine_and_a: assert property (andCombine && !(firstSummary && thirdSummary)
        |-> !cpuIrqRequest)
        else $error("and-combined request with one source idle");
    combine_or_a: assert property (!andCombine && (firstSummary || thirdSummary)
        |-> cpuIrqRequest)
        else $error("or-combined request missing");
    status_direct_a: assert property (rdStrobe && addr == ADDR_A_STATUS
        |=> rdData == $past(aSync2))
        else $error("status read not the sampled pins");
    stable_needs_two_a: assert property ($changed(aStable) |->
        ((aStable ^ $past(aStable)) &
         ((aStable ^ $past(aSample)) | (aStable ^ $past(aSync2)))) == 4'h0)
        else $error("debounced level changed without two matching ticks");
    dir_b_drive_a: assert property (!sleepHiz |-> portBOe_n == ~secondPortDirection)
        else $error("second-port drive does not follow direction");
    sleep_hiz_a: assert property (sleepHiz |-> (portBOe_n & portCOe_n) == 4'hF)
        else $error("output driven in sleep");

    cov_flag_read: cover property (|firstIrqFlags ##1 rdAFlags);
    cov_and_req: cover property (andCombine && cpuIrqRequest);
    cov_third_flag: cover property (|thirdIrqFlags);
    cov_debounce: cover property (debTick && aStable != aSample);
    cov_slow_tick: cover property (debounceSlowSelect && debTick);

    // Edge polarity: the selected edge sets its flag, the other one never does.
    fall_sets_a: assert property (!risingSel && |aFallMasked |=>
        (firstIrqFlags & $past(aFallMasked)) == $past(aFallMasked))
        else $error("masked falling edge did not set its flag");
    rise_sets_a: assert property (risingSel && |aRiseMasked |=>
        (firstIrqFlags & $past(aRiseMasked)) == $past(aRiseMasked))
        else $error("masked rising edge did not set its flag");
    wrong_edge_a: assert property (!risingSel && !rdAFlags |=>
        ((firstIrqFlags & ~$past(firstIrqFlags)) & $past(aRiseMasked)) == 4'h0)
        else $error("rising edge flagged while falling edges selected");
    c_fall_sets_a: assert property (!risingSel && |cFallMasked |=>
        (thirdIrqFlags & $past(cFallMasked)) == $past(cFallMasked))
        else $error("third-port falling edge did not set its flag");
    c_rise_sets_a: assert property (risingSel && |cRiseMasked |=>
        (thirdIrqFlags & $past(cRiseMasked)) == $past(cRiseMasked))
        else $error("third-port rising edge did not set its flag");

    // Flags are sticky until read and cannot be written.
    flags_hold_a: assert property (!rdAFlags |=>
        (firstIrqFlags & $past(firstIrqFlags)) == $past(firstIrqFlags))
        else $error("first-port flag lost without a read");
    flags_hold_c_a: assert property (!rdCFlags |=>
        (thirdIrqFlags & $past(thirdIrqFlags)) == $past(thirdIrqFlags))
        else $error("third-port flag lost without a read");
    read_clears_c_a: assert property (rdCFlags && !(|cSet) |=> thirdIrqFlags == 4'h0)
        else $error("third-port flags survived a read");
    no_write_flags_a: assert property (wrStrobe && addr == ADDR_A_FLAGS && !(|aSet)
        |=> firstIrqFlags == $past(firstIrqFlags))
        else $error("first-port flags changed by a write");

    // Debounced levels move only on a tick, and only after two agreeing ticks.
    stable_tick_a: assert property (!$past(debTick) |->
        $stable(aStable) && $stable(cStable))
        else $error("debounced level moved between ticks");
    stable_c_two_a: assert property ($changed(cStable) |->
        ((cStable ^ $past(cStable)) & (cStable ^ $past(cSample))) == 4'h0)
        else $error("third-port level changed without two matching ticks");

    // Drive and readback of the bidirectional ports.
    third_dir_drive_a: assert property (!sleepHiz |-> portCOe_n == {4{~thirdIsOut}})
        else $error("third-port drive does not follow direction");
    b_read_direct_a: assert property (!INPUT_BLOCKED_ON_OUTPUT && rdStrobe &&
        addr == ADDR_B_DATA |=> rdData == $past(bSync2))
        else $error("second-port read not the pin levels");
    b_read_blocked_a: assert property (INPUT_BLOCKED_ON_OUTPUT && rdStrobe &&
        addr == ADDR_B_DATA |=> (rdData & $past(secondPortDirection)) == 4'h0)
        else $error("second-port output pin visible to a read");
    c_read_blocked_a: assert property (INPUT_BLOCKED_ON_OUTPUT && thirdIsOut &&
        rdStrobe && addr == ADDR_C_DATA |=> rdData == 4'h0)
        else $error("third-port output pins visible to a read");

    // Request combining and the exports.
    and_both_a: assert property (firstSummary && thirdSummary |-> cpuIrqRequest)
        else $error("request missing with both sources pending");
    irq_idle_a: assert property (!firstSummary && !thirdSummary |-> !cpuIrqRequest)
        else $error("request raised with no source pending");
    branch_follows_a: assert property (
        {branchTest3, branchTest2, branchTest1} == aStable[2:0])
        else $error("branch inputs not the debounced pins");
    wd_follows_a: assert property (
        watchdogDisable == portOptions[OPT_WATCHDOG_DISABLE])
        else $error("watchdog export not the option bit");

endmodule // quad_nibble_io_ports

// [hw/quad_nibble_pkg.sv]
package quad_nibble_pkg;

    // Register indices on the nibble register port.
    localparam logic [3:0] ADDR_OPTIONS     = 4'h0;
    localparam logic [3:0] ADDR_A_STATUS    = 4'h1;
    localparam logic [3:0] ADDR_A_FLAGS     = 4'h2;
    localparam logic [3:0] ADDR_A_MASK      = 4'h3;
    localparam logic [3:0] ADDR_B_DATA      = 4'h4;
    localparam logic [3:0] ADDR_B_DIR       = 4'h5;
    localparam logic [3:0] ADDR_C_DATA      = 4'h6;
    localparam logic [3:0] ADDR_CONTROL     = 4'h7;
    localparam logic [3:0] ADDR_C_MASK      = 4'h8;
    localparam logic [3:0] ADDR_C_FLAGS     = 4'h9;
    localparam logic [3:0] ADDR_IRQ_REQUEST = 4'hA;

    // Option register fields.
    localparam int OPT_WATCHDOG_DISABLE = 0;
    localparam int OPT_FIRST_BYPASS     = 1;
    localparam int OPT_THIRD_BYPASS     = 2;
    localparam int OPT_RISING_SELECT    = 3;

    // Port control register fields.
    localparam int CTL_AND_COMBINE      = 0;
    localparam int CTL_THIRD_DIRECTION  = 1;

    // Central request register fields.
    localparam int REQ_FIRST_SUMMARY    = 0;
    localparam int REQ_THIRD_SUMMARY    = 1;

    // Reset values.
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    localparam logic [3:0] READ_UNMAPPED = 4'h0;

    // Debounce clock rates and the derived cycle counts of their periods.
    localparam longint CLK_HZ       = 125000000;
    localparam longint FAST_TAP_HZ  = 1024;
    localparam longint SLOW_TAP_HZ  = 128;
    localparam int FAST_TAP_CYCLES  = int'(CLK_HZ / FAST_TAP_HZ);
    localparam int SLOW_TAP_CYCLES  = int'(CLK_HZ / SLOW_TAP_HZ);
    localparam int DIV_WIDTH        = 20;

endpackage

// [verif/board_pins.sv]
`timescale 1ns/1ps
// Board-side pins. A pin that nobody drives falls to its pull-down, so a released
// line never keeps its last driven level by accident.
module board_pins (
    // Levels set by the bench.
    input  wire logic [3:0] aLevel,
    input  wire logic [3:0] bExt,
    input  wire logic [3:0] bExtEn,
    input  wire logic [3:0] cExt,
    input  wire logic [3:0] cExtEn,
    // Drive from the design.
    input  wire logic [3:0] portBOut,
    input  wire logic [3:0] portBOe_n,
    input  wire logic [3:0] portCOut,
    input  wire logic [3:0] portCOe_n,
    // Pin levels seen by the design.
    output logic      [3:0] portAIn,
    output logic      [3:0] portBIn,
    output logic      [3:0] portCIn
);
    // Design drive wins where enabled; contention is not modelled.
    assign portAIn = aLevel;
    assign portBIn = (~portBOe_n & portBOut) | (portBOe_n & bExtEn & bExt);
    assign portCIn = (~portCOe_n & portCOut) | (portCOe_n & cExtEn & cExt);
endmodule // board_pins

// [verif/quad_nibble_io_ports_bench.sv]
`timescale 1ns/1ps
module quad_nibble_io_ports_bench;
    import quad_nibble_pkg::*;
    logic       ref_clk, rst, wrStrobe, rdStrobe, sleepMode, debounceSlowSelect;
    logic [3:0] addr, wrData, rdData, portAIn, portBIn, portCIn;
    logic [3:0] portBOut, portBOe_n, portCOut, portCOe_n;
    logic       watchdogDisable, branchTest1, branchTest2, branchTest3, cpuIrqRequest;
    logic [3:0] aLevel, bExt, bExtEn, cExt, cExtEn;
    logic [3:0] optRdData, optBOe_n;
    int         fails, numChecks;

    // Short tap periods keep the debounce waits to a few dozen cycles.
    quad_nibble_io_ports #(.FAST_DIV(8), .SLOW_DIV(16)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .portAIn(portAIn), .portBIn(portBIn),
        .portBOut(portBOut), .portBOe_n(portBOe_n), .portCIn(portCIn),
        .portCOut(portCOut), .portCOe_n(portCOe_n), .sleepMode(sleepMode),
        .debounceSlowSelect(debounceSlowSelect), .watchdogDisable(watchdogDisable),
        .branchTest1(branchTest1), .branchTest2(branchTest2), .branchTest3(branchTest3),
        .cpuIrqRequest(cpuIrqRequest));

    // Second copy with both build options, fed the same bus and pins.
    quad_nibble_io_ports #(.FAST_DIV(8), .SLOW_DIV(16), .INPUT_BLOCKED_ON_OUTPUT(1'b1),
        .HIZ_IN_SLEEP(1'b1)) i_dut_opt (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(optRdData), .portAIn(portAIn), .portBIn(portBIn),
        .portBOut(), .portBOe_n(optBOe_n), .portCIn(portCIn), .portCOut(),
        .portCOe_n(), .sleepMode(sleepMode), .debounceSlowSelect(debounceSlowSelect),
        .watchdogDisable(), .branchTest1(), .branchTest2(), .branchTest3(),
        .cpuIrqRequest());

    board_pins i_pins (
        .aLevel(aLevel), .bExt(bExt), .bExtEn(bExtEn), .cExt(cExt), .cExtEn(cExtEn),
        .portBOut(portBOut), .portBOe_n(portBOe_n), .portCOut(portCOut),
        .portCOe_n(portCOe_n), .portAIn(portAIn), .portBIn(portBIn), .portCIn(portCIn));

    // 125 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        numChecks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One-cycle write strobe; the effect shows one cycle later.
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge ref_clk);
        wrStrobe <= 1'b1;
        addr     <= a;
        wrData   <= d;
        @(posedge ref_clk);
        wrStrobe <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [3:0] a, input logic [3:0] exp, input string what);
        @(posedge ref_clk);
        rdStrobe <= 1'b1;
        addr     <= a;
        @(posedge ref_clk);
        rdStrobe <= 1'b0;
        #1;
        check(what, exp, rdData);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // A hang is cut off well beyond the few hundred cycles the sequence needs.
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        give_verdict();
    end

    initial begin
        rst = 1'b1; wrStrobe = 1'b0; rdStrobe = 1'b0; addr = 4'h0; wrData = 4'h0;
        sleepMode = 1'b0; debounceSlowSelect = 1'b0; aLevel = 4'h0;
        bExt = 4'h0; bExtEn = 4'h0; cExt = 4'h0; cExtEn = 4'h0;
        idle(20);
        rst <= 1'b0;
        check("portBOe_n", 4'hF, portBOe_n);
        check("portCOe_n", 4'hF, portCOe_n);
        check("watchdog", 4'h0, {3'h0, watchdogDisable});
        rd(ADDR_OPTIONS, 4'h0, "options");
        rd(ADDR_A_MASK, 4'h0, "maskA");
        rd(ADDR_B_DIR, 4'h0, "dirB");
        rd(ADDR_CONTROL, 4'h0, "control");
        rd(ADDR_C_MASK, 4'h0, "maskC");
        rd(ADDR_A_FLAGS, 4'h0, "flagsA");
        wr(ADDR_OPTIONS, 4'h1);
        idle(1);
        check("watchdog", 4'h1, {3'h0, watchdogDisable});
        wr(ADDR_A_STATUS, 4'hF);
        rd(ADDR_A_STATUS, 4'h0, "statusA");
        rd(4'hF, 4'h0, "unmapped");
        // Debounced branch inputs lag the raw status, on both taps.
        @(posedge ref_clk) aLevel <= 4'h7;
        idle(4);
        rd(ADDR_A_STATUS, 4'h7, "statusA");
        check("branch", 4'h0, {1'b0, branchTest3, branchTest2, branchTest1});
        idle(30);
        check("branch", 4'h7, {1'b0, branchTest3, branchTest2, branchTest1});
        @(posedge ref_clk) debounceSlowSelect <= 1'b1;
        aLevel <= 4'h0;
        idle(12);
        check("branch", 4'h7, {1'b0, branchTest3, branchTest2, branchTest1});
        idle(40);
        check("branch", 4'h0, {1'b0, branchTest3, branchTest2, branchTest1});
        debounceSlowSelect <= 1'b0;
        // First port with bypass: mask gating, falling edges, clear on read.
        wr(ADDR_OPTIONS, 4'h2);
        @(posedge ref_clk) aLevel <= 4'hF;
        idle(6);
        aLevel <= 4'h0;
        idle(6);
        rd(ADDR_A_FLAGS, 4'h0, "flagsA");
        wr(ADDR_A_MASK, 4'hF);
        @(posedge ref_clk) aLevel <= 4'hF;
        idle(6);
        check("irq", 4'h0, {3'h0, cpuIrqRequest});
        aLevel <= 4'h5;
        idle(6);
        check("irq", 4'h1, {3'h0, cpuIrqRequest});
        rd(ADDR_IRQ_REQUEST, 4'h1, "request");
        rd(ADDR_A_FLAGS, 4'hA, "flagsA");
        rd(ADDR_A_FLAGS, 4'h0, "flagsA");
        rd(ADDR_IRQ_REQUEST, 4'h0, "request");
        wr(ADDR_OPTIONS, 4'hA);
        @(posedge ref_clk) aLevel <= 4'hF;
        idle(6);
        rd(ADDR_A_FLAGS, 4'hA, "flagsA");
        // Debounced interrupt path needs two ticks before a flag appears.
        idle(30);
        wr(ADDR_OPTIONS, 4'h8);
        @(posedge ref_clk) aLevel <= 4'h0;
        idle(30);
        aLevel <= 4'h1;
        idle(6);
        rd(ADDR_A_FLAGS, 4'h0, "flagsA");
        idle(30);
        rd(ADDR_A_FLAGS, 4'h1, "flagsA");
        // Second port: per-bit direction, pin readback, no tristate in sleep.
        wr(ADDR_B_DIR, 4'h3);
        wr(ADDR_B_DATA, 4'hA);
        @(posedge ref_clk) bExt <= 4'h4;
        bExtEn <= 4'hC;
        idle(3);
        check("portBOe_n", 4'hC, portBOe_n);
        check("portBOut", 4'hA, portBOut);
        rd(ADDR_B_DATA, 4'h6, "dataB");
        check("optDataB", 4'h4, optRdData);
        @(posedge ref_clk) sleepMode <= 1'b1;
        idle(2);
        check("portBOe_n", 4'hC, portBOe_n);
        check("optBOe_n", 4'hF, optBOe_n);
        sleepMode <= 1'b0;
        // Third port: whole-port direction, flags only as input, AND and OR combine.
        wr(ADDR_C_MASK, 4'hF);
        wr(ADDR_OPTIONS, 4'hC);
        wr(ADDR_CONTROL, 4'h2);
        wr(ADDR_C_DATA, 4'hF);
        idle(6);
        check("portCOe_n", 4'h0, portCOe_n);
        check("portCOut", 4'hF, portCOut);
        rd(ADDR_C_FLAGS, 4'h0, "flagsC");
        wr(ADDR_CONTROL, 4'h1);
        idle(4);
        check("portCOe_n", 4'hF, portCOe_n);
        @(posedge ref_clk) cExtEn <= 4'hF;
        cExt <= 4'hF;
        idle(6);
        check("irq", 4'h0, {3'h0, cpuIrqRequest});
        @(posedge ref_clk) aLevel <= 4'hF;
        idle(40);
        check("irq", 4'h1, {3'h0, cpuIrqRequest});
        wr(ADDR_CONTROL, 4'h0);
        rd(ADDR_A_FLAGS, 4'hE, "flagsA");
        check("irq", 4'h1, {3'h0, cpuIrqRequest});
        rd(ADDR_C_FLAGS, 4'hF, "flagsC");
        check("irq", 4'h0, {3'h0, cpuIrqRequest});
        give_verdict();
    end
endmodule // quad_nibble_io_ports_bench
